// ---- verilog/acdc_consts.svh ----
// Constants of the comparator and reference DAC control block.
`ifndef ACDC_CONSTS_SVH
`define ACDC_CONSTS_SVH
`define ACDC_NCMP 4
`define ACDC_DAC_W 10
`define ACDC_FILT_CYC 2
`define ACDC_OFF_CTRL 8'h00
`define ACDC_OFF_DAC0 8'h04
`define ACDC_OFF_STAT 8'h14
`define ACDC_OFF_MASK 8'h18
`define ACDC_OFF_STATE 8'h1c
`define ACDC_CTRL_EN 0
`define ACDC_CTRL_POL 1
`define ACDC_CTRL_SIDL 2
`define ACDC_CTRL_DAC_OUTPUT_ENABLE 3
`define ACDC_CTRL_RNG 4
`define ACDC_CTRL_SRC 6
`define ACDC_CTRL_RST 8'h00
`define ACDC_DAC_RST 10'h000
`define ACDC_RNG_HALF 2'h0
`define ACDC_RNG_INT 2'h1
`define ACDC_RNG_EXT 2'h2
`endif

// ---- verilog/acdc_pkg.sv ----
// Types of the comparator and reference DAC control block.
package acdc_pkg;
  typedef enum logic [1:0] {
    ACDC_WR_IDLE = 2'b01,
    ACDC_WR_RESP = 2'b10
  } acdc_wr_t;
  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic [3:0][9:0] dac;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] filt;
    logic [3:0][1:0] cnt;
    logic [3:0] prev;
    logic [3:0] pulse;
    logic [3:0] fault;
    logic sleep_s1;
    logic sleep_s2;
    logic idle_s1;
    logic idle_s2;
    acdc_wr_t wst;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic have_aw;
    logic have_w;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } acdc_state_t;
endpackage

// ---- verilog/acdc_top.sv ----
// Comparator control: filter, polarity, pulses, DAC reference and register slave.
`timescale 1ns/100ps
`include "acdc_consts.svh"
module acdc_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] cmp_raw,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic pwm_fault_clear,
  output logic [3:0] cmp_out,
  output logic [3:0] adc_trigger,
  output logic [3:0] cmp_irq_pulse,
  output logic [3:0] pwm_current_limit,
  output logic [3:0] pwm_current_min,
  output logic [3:0] pwm_fault,
  output logic [3:0] wake_async,
  output logic [3:0] cmp_power_on,
  output logic [3:0] dac_power_on,
  output logic [3:0][9:0] dac_code,
  output logic [3:0][1:0] dac_range,
  output logic [3:0][1:0] pad_select,
  output logic [3:0] pad_input_disable,
  output logic [9:0] dac_output_pin_code,
  output logic dac_output_pin_oe,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import acdc_pkg::*;

  acdc_state_t st_reg;
  acdc_state_t st_next;
  logic group_stop;
  logic low_power;
  logic [3:0] active;
  logic [3:0] qual;

  // --------------------------------------------------------------
  // Address decoding
  // --------------------------------------------------------------
  // Returns the comparator index of a DAC value register, or 4 when none.
  function automatic logic [2:0] dac_index(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h4;
    if (a >= `ACDC_OFF_DAC0 && a < `ACDC_OFF_STAT && a[1:0] == 2'h0) begin
      r = 3'((a - `ACDC_OFF_DAC0) >> 2);
    end
    return r;
  endfunction

  // Tells whether an address names a register at all.
  function automatic logic mapped(input logic [7:0] a);
    return (a == `ACDC_OFF_CTRL) || (dac_index(a) != 3'h4) || (a == `ACDC_OFF_STAT) ||
      (a == `ACDC_OFF_MASK) || (a == `ACDC_OFF_STATE);
  endfunction

  // --------------------------------------------------------------
  // Register read data
  // --------------------------------------------------------------
  // Builds the word returned for a read; unmapped addresses read as zero.
  function automatic logic [31:0] read_word(input acdc_state_t s, input logic [7:0] a);
    logic [31:0] w;
    logic [2:0] k;
    w = 32'h0;
    k = dac_index(a);
    if (a == `ACDC_OFF_CTRL) begin
      w = s.ctrl;
    end else if (k != 3'h4) begin
      w = {22'h0, s.dac[k[1:0]]};
    end else if (a == `ACDC_OFF_STAT) begin
      w = {28'h0, s.stat};
    end else if (a == `ACDC_OFF_MASK) begin
      w = {28'h0, s.mask};
    end else if (a == `ACDC_OFF_STATE) begin
      w = {24'h0, s.fault, s.filt};
    end
    return w;
  endfunction

  // --------------------------------------------------------------
  // Register write data
  // --------------------------------------------------------------
  // Merges the strobed bytes of a write into the old word of a register.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        w[8*b +: 8] = d[8*b +: 8];
      end
    end
    return w;
  endfunction

  // --------------------------------------------------------------
  // Power and grouping
  // --------------------------------------------------------------
  always_comb begin
    group_stop = 1'b0;
    for (int i = 0; i < `ACDC_NCMP; i++) begin
      group_stop = group_stop | st_reg.ctrl[i][`ACDC_CTRL_SIDL];
    end
    // One stop bit stops the whole set, which keeps the idle clock control simple.
    group_stop = group_stop & st_reg.idle_s2;
    low_power = st_reg.sleep_s2 | st_reg.idle_s2;
  end

  // Combinational on purpose: the wake path must work with the clock stopped.
  genvar g;
  generate
    for (g = 0; g < `ACDC_NCMP; g++) begin : g_cmp
      assign active[g] = st_reg.ctrl[g][`ACDC_CTRL_EN] & ~group_stop;
      assign cmp_power_on[g] = active[g];
      assign dac_power_on[g] = active[g];
      assign dac_code[g] = st_reg.dac[g];
      assign dac_range[g] = st_reg.ctrl[g][`ACDC_CTRL_RNG +: 2];
      assign pad_select[g] = st_reg.ctrl[g][`ACDC_CTRL_SRC +: 2];
      assign pad_input_disable[g] = st_reg.ctrl[g][`ACDC_CTRL_EN];
      assign wake_async[g] = active[g] & (sleep_mode | idle_mode) &
        (cmp_raw[g] ^ st_reg.ctrl[g][`ACDC_CTRL_POL]);
      assign qual[g] = active[g] & st_reg.filt[g] & ~st_reg.prev[g];
    end
  endgenerate

  // --------------------------------------------------------------
  // DAC output pin
  // --------------------------------------------------------------
  always_comb begin
    dac_output_pin_code = 10'h000;
    dac_output_pin_oe = 1'b0;
    // Lowest index wins; with several enables the pin value is not defined anyway.
    for (int i = `ACDC_NCMP - 1; i >= 0; i--) begin
      if (st_reg.ctrl[i][`ACDC_CTRL_DAC_OUTPUT_ENABLE] && active[i]) begin
        dac_output_pin_code = st_reg.dac[i];
        dac_output_pin_oe = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    logic wr_fire;
    logic [2:0] di;
    logic [3:0] clr;
    wr_fire = 1'b0;
    di = 3'h4;
    clr = 4'h0;
    st_next = st_reg;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Two stages let a metastable first stage settle before anything counts.
    st_next.s1 = cmp_raw;
    st_next.s2 = st_reg.s1;
    st_next.sleep_s1 = sleep_mode;
    st_next.sleep_s2 = st_reg.sleep_s1;
    st_next.idle_s1 = idle_mode;
    st_next.idle_s2 = st_reg.idle_s1;

    // ------------------------------------------------------------
    // Glitch filter and polarity
    // ------------------------------------------------------------
    // Outside sleep and idle, a change must stand for two cycles in a row before it is believed; in low power it passes at once.
    for (int i = 0; i < `ACDC_NCMP; i++) begin
      logic pol;
      pol = st_reg.s2[i] ^ st_reg.ctrl[i][`ACDC_CTRL_POL];
      if (!active[i]) begin
        st_next.filt[i] = 1'b0;
        st_next.cnt[i] = 2'h0;
      end else if (low_power) begin
        st_next.filt[i] = pol;
        st_next.cnt[i] = 2'h0;
      end else if (pol == st_reg.filt[i]) begin
        st_next.cnt[i] = 2'h0;
      end else if (st_reg.cnt[i] == 2'(`ACDC_FILT_CYC - 1)) begin
        st_next.filt[i] = pol;
        st_next.cnt[i] = 2'h0;
      end else begin
        st_next.cnt[i] = st_reg.cnt[i] + 2'h1;
      end
    end

    // ------------------------------------------------------------
    // Event pulse and fault latch
    // ------------------------------------------------------------
    // A new event outranks a simultaneous clear of the fault latch.
    st_next.prev = st_reg.filt;
    st_next.pulse = qual;
    for (int i = 0; i < `ACDC_NCMP; i++) begin
      if (pwm_fault_clear) begin
        st_next.fault[i] = 1'b0;
      end
      if (qual[i]) begin
        st_next.fault[i] = 1'b1;
      end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order.
    if (s_axi_awvalid && !st_reg.have_aw && st_reg.wst == ACDC_WR_IDLE) begin
      st_next.have_aw = 1'b1;
      st_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.have_w && st_reg.wst == ACDC_WR_IDLE) begin
      st_next.have_w = 1'b1;
      st_next.wdata = s_axi_wdata;
      // Strobes travel with the data; the master may move them once data is taken.
      st_next.wstrb = s_axi_wstrb;
    end
    case (st_reg.wst)
      ACDC_WR_IDLE: begin
        if (st_reg.have_aw && st_reg.have_w) begin
          wr_fire = 1'b1;
          st_next.wst = ACDC_WR_RESP;
          st_next.have_aw = 1'b0;
          st_next.have_w = 1'b0;
          st_next.bresp = mapped(st_reg.waddr) ? 2'h0 : 2'h2;
        end
      end
      ACDC_WR_RESP: begin
        if (s_axi_bready) begin
          st_next.wst = ACDC_WR_IDLE;
        end
      end
      default: st_next.wst = ACDC_WR_IDLE;
    endcase
    di = dac_index(st_reg.waddr);
    if (wr_fire) begin
      if (st_reg.waddr == `ACDC_OFF_CTRL) begin
        st_next.ctrl = merge_bytes(st_reg.ctrl, st_reg.wdata, st_reg.wstrb);
      end else if (di != 3'h4) begin
        if (st_reg.wstrb[0]) begin
          st_next.dac[di[1:0]][7:0] = st_reg.wdata[7:0];
        end
        if (st_reg.wstrb[1]) begin
          st_next.dac[di[1:0]][9:8] = st_reg.wdata[9:8];
        end
      end else if (st_reg.waddr == `ACDC_OFF_STAT && st_reg.wstrb[0]) begin
        clr = st_reg.wdata[3:0];
      end else if (st_reg.waddr == `ACDC_OFF_MASK && st_reg.wstrb[0]) begin
        st_next.mask = st_reg.wdata[3:0];
      end
    end
    // A new event outranks a simultaneous write-one clear.
    st_next.stat = (st_reg.stat & ~clr) | qual;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    if (st_reg.rvalid) begin
      if (s_axi_rready) begin
        st_next.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      st_next.rdata = read_word(st_reg, s_axi_araddr);
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= {4{`ACDC_CTRL_RST}};
      st_reg.dac <= {4{`ACDC_DAC_RST}};
      st_reg.wst <= ACDC_WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // cmp_out, pwm_current_limit and pwm_current_min see the filtered result; adc_trigger its pulse, cmp_irq_pulse that ORed with wake_async.
  generate
    for (g = 0; g < `ACDC_NCMP; g++) begin : g_out
      assign cmp_out[g] = st_reg.filt[g];
      assign adc_trigger[g] = st_reg.pulse[g];
      assign cmp_irq_pulse[g] = st_reg.pulse[g] | wake_async[g];
      assign pwm_current_limit[g] = st_reg.filt[g];
      assign pwm_current_min[g] = st_reg.filt[g];
      assign pwm_fault[g] = st_reg.fault[g];
    end
  endgenerate

  // --------------------------------------------------------------
  // Interrupt
  // --------------------------------------------------------------
  // A level, so an event that lands while software clears is not lost.
  assign irq = |(st_reg.stat & st_reg.mask);

  // --------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------
  assign s_axi_awready = st_reg.wst == ACDC_WR_IDLE && !st_reg.have_aw;
  assign s_axi_wready = st_reg.wst == ACDC_WR_IDLE && !st_reg.have_w;
  assign s_axi_bvalid = st_reg.wst == ACDC_WR_RESP;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule // acdc_top

// ---- sim/acdc_props.sv ----
// Concurrent checks on the comparator control block ports.
`timescale 1ns/100ps
module acdc_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] cmp_raw,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic pwm_fault_clear,
  input wire logic [3:0] cmp_out,
  input wire logic [3:0] adc_trigger,
  input wire logic [3:0] cmp_irq_pulse,
  input wire logic [3:0] pwm_current_limit,
  input wire logic [3:0] pwm_current_min,
  input wire logic [3:0] pwm_fault,
  input wire logic [3:0] wake_async,
  input wire logic [3:0] cmp_power_on,
  input wire logic [3:0] dac_power_on,
  input wire logic [3:0] pad_input_disable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire nrm = !sleep_mode && !idle_mode;
  // ----------------
  // Checks
  // ----------------
  AST_TRIG_ONE: assert property (adc_trigger[0] |=> !adc_trigger[0])
    else $error("trigger wider than one cycle");
  AST_TRIG_RISE: assert property ($rose(cmp_out[0]) |=> adc_trigger[0])
    else $error("no trigger after rise");
  AST_IRQ_PULSE: assert property (nrm |-> cmp_irq_pulse == adc_trigger)
    else $error("irq pulse differs from trigger");
  AST_PWM_USE: assert property (pwm_current_limit == cmp_out && pwm_current_min == cmp_out)
    else $error("pwm outputs differ from result");
  AST_FAULT_HOLD: assert property (pwm_fault[0] && !pwm_fault_clear |=> pwm_fault[0])
    else $error("fault latch lost");
  // Raw input kept quiet first, so earlier edges cannot still be in flight.
  AST_GLITCH: assert property ((nrm && !cmp_raw[0])[*4] ##1 cmp_raw[0] ##1 !cmp_raw[0]
    |=> $stable(cmp_out[0])[*6])
    else $error("short glitch passed filter");
  AST_SYNC: assert property ((nrm && !cmp_raw[0])[*8] ##1 cmp_raw[0] |-> $stable(cmp_out[0])[*4])
    else $error("result moved before synchroniser");
  AST_WAKE_OFF: assert property (nrm |-> wake_async == 4'h0)
    else $error("wake path active in run mode");
  AST_POWER: assert property (((cmp_power_on | dac_power_on) & ~pad_input_disable) == 4'h0)
    else $error("power on while disabled");
  cover property ($rose(cmp_out[0]));
  cover property (wake_async[0]);
  cover property (pwm_fault[0] && pwm_fault_clear);
endmodule // acdc_props

// ---- sim/acdc_far.sv ----
// Downstream model: counts trigger pulses and clears the fault latch.
`timescale 1ns/100ps
module acdc_far (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] adc_trigger,
  input wire logic clear_req,
  output logic pwm_fault_clear,
  output int trig_seen
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwm_fault_clear <= 1'b0;
      trig_seen <= 0;
    end else begin
      pwm_fault_clear <= clear_req;
      trig_seen <= trig_seen + $countones(adc_trigger);
    end
  end
endmodule // acdc_far

// ---- sim/testbench.sv ----
// Self-checking bench for the comparator control block.
`timescale 1ns/100ps
module testbench;
  import acdc_pkg::*;
  logic clock, arst_n, sleep_mode, idle_mode, clr, pwm_fault_clear, irq, dac_output_pin_oe;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] cmp_raw, cmp_out, adc_trigger, cmp_irq_pulse, pwm_current_limit, pwm_current_min;
  logic [3:0] pwm_fault, wake_async, cmp_power_on, dac_power_on, pad_input_disable, s_axi_wstrb;
  logic [3:0][9:0] dac_code;
  logic [3:0][1:0] dac_range, pad_select;
  logic [9:0] dac_output_pin_code;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, bs, rs;
  int failures = 0, tests_run = 0, trig_seen;
  acdc_top uut (.clock, .arst_n, .cmp_raw, .sleep_mode, .idle_mode, .pwm_fault_clear,
    .cmp_out, .adc_trigger, .cmp_irq_pulse, .pwm_current_limit, .pwm_current_min,
    .pwm_fault, .wake_async, .cmp_power_on, .dac_power_on, .dac_code, .dac_range,
    .pad_select, .pad_input_disable, .dac_output_pin_code, .dac_output_pin_oe, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  acdc_far far (.clock, .arst_n, .adc_trigger, .clear_req(clr), .pwm_fault_clear, .trig_seen);
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0; bs = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0; rv = s_axi_rdata; rs = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    #2000000;
    failures++;
    give_verdict;
  end
  initial begin
    arst_n = 0; cmp_raw = 0; sleep_mode = 0; idle_mode = 0; clr = 0; s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
    cyc(16); arst_n <= 1'b1;
    rc(8'h00, 0);
    rc(8'h04, 0);
    rd(8'h20); chk(rs, 2'h2);
    wr(8'h24, 1); chk(bs, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h01 | (i << 4) | (i << 6)); chk(dac_range[0], i);
      chk(pad_select[0], i);
      chk(pad_input_disable, 4'h1);
    end
    wr(8'h04, 32'h3ff); wr(8'h08, 32'h155); wr(8'h00, 32'h901);
    chk(dac_code[0], 10'h3ff);
    rc(8'h04, 32'h3ff);
    chk({dac_output_pin_oe, dac_output_pin_code}, 11'h555);
    s_axi_wstrb <= 4'h1;
    wr(8'h04, 32'h2aa);
    s_axi_wstrb <= 4'hf;
    rc(8'h04, 32'h3aa);
    cmp_raw <= 4'h1; cyc(1); cmp_raw <= 4'h0; cyc(8);
    chk(cmp_out, 0); chk(trig_seen, 0);
    cmp_raw <= 4'h1; cyc(8);
    chk(cmp_out, 1); chk(pwm_fault, 1);
    chk(trig_seen, 1); rc(8'h14, 1);
    rc(8'h1c, 32'h11); chk(irq, 0);
    wr(8'h18, 1); chk(irq, 1);
    wr(8'h14, 1); chk(irq, 0);
    wr(8'h00, 32'h903); cyc(6); chk(cmp_out, 0);
    wr(8'h00, 32'h901); cyc(6); chk(trig_seen, 2);
    cmp_raw <= 4'h0; cyc(6); clr <= 1'b1; cyc(3); clr <= 1'b0;
    chk(pwm_fault, 0);
    wr(8'h00, 32'h501); idle_mode <= 1'b1; cyc(4);
    chk(cmp_power_on, 0);
    idle_mode <= 1'b0; cyc(4); chk(cmp_power_on, 4'h3);
    wr(8'h00, 32'h1); sleep_mode <= 1'b1; cyc(4); cmp_raw <= 4'h1; #10;
    chk(wake_async, 4'h1); chk(cmp_irq_pulse[0], 1);
    cyc(1); cmp_raw <= 4'h0; sleep_mode <= 1'b0; cyc(8);
    wr(8'h00, 0); chk(cmp_power_on | dac_power_on, 0);
    chk(pad_input_disable, 0);
    give_verdict;
  end
endmodule // testbench
bind acdc_top acdc_props chk_i (.clock, .arst_n, .cmp_raw, .sleep_mode, .idle_mode,
  .pwm_fault_clear, .cmp_out, .adc_trigger, .cmp_irq_pulse, .pwm_current_limit,
  .pwm_current_min, .pwm_fault, .wake_async, .cmp_power_on, .dac_power_on,
  .pad_input_disable);
